// ==== drive_option_pkg.sv ====
// Purpose : Shared constants for the haptic drive option register bank
// Assumes : 8-bit registers on an internal register port, 100 MHz clock
// Notes   : Field positions, reset values and time base live here; lookup tables are in option_time_decode

package drive_option_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DRIVE_OPTION = 8'h1D;
  localparam logic [7:0] ADDR_TIMING_CAL   = 8'h1E;
  localparam logic [7:0] ADDR_FALLBACK     = 8'h1F;
  localparam logic [7:0] ADDR_OL_PERIOD    = 8'h20;

  localparam logic [7:0] RST_DRIVE_OPTION = 8'hA0;
  localparam logic [3:0] RST_TIMING_CAL   = 4'h2;
  localparam logic [7:0] RST_FALLBACK     = 8'h80;
  localparam logic [6:0] RST_OL_PERIOD    = 7'h00;

  // Drive option fields
  localparam int GATE_HI      = 7;
  localparam int GATE_LO      = 6;
  localparam int BIT_ROT_OL   = 5;
  localparam int BIT_COMP_OFF = 4;
  localparam int BIT_UNSIGNED = 3;
  localparam int BIT_TWICE    = 2;
  localparam int BIT_ANALOG   = 1;
  localparam int BIT_LIN_OL   = 0;
  // Timing/calibration fields (upper nibble only is stored)
  localparam int ZC_HI  = 3;
  localparam int ZC_LO  = 2;
  localparam int CAL_HI = 1;
  localparam int CAL_LO = 0;
  // Fallback/interval fields
  localparam int SYNC_HI  = 7;
  localparam int SYNC_LO  = 6;
  localparam int BIT_FBEN = 5;
  localparam int BIT_IVAL = 4;
  localparam int BLANK_HI = 3;
  localparam int BLANK_LO = 2;
  localparam int IDISS_HI = 1;
  localparam int IDISS_LO = 0;

  // ----------------------------------------------------------------------
  // Modes, time base and tables
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_PWM_ANALOG = 3'h3;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         NS_PER_US       = 1000;
  localparam int         US_PER_MS       = 1000;
  localparam int         OL_STEP_NS      = 98460;  // 98.46 us per period LSB
  localparam int         PWM_DIVIDE      = 128;
  localparam int         SYNC_BASE       = 3;      // attempts at code 0
  localparam int         IVAL_SLOW_US    = 5000;
  localparam int         IVAL_FAST_US    = 1000;

  typedef enum logic [1:0] {
    FREQ_AUTO   = 2'b00,
    FREQ_PWM    = 2'b01,
    FREQ_PERIOD = 2'b10
  } freq_src_e;

endpackage

// ==== option_time_decode.sv ====
// Purpose : Turns option codes into gate levels and times in us or ms
// Assumes : Purely combinational; the caller registers every result except sync_limit and ival_us
// Notes   : Times are returned in their own unit, converted by the caller

`timescale 1ns/10ps

module option_time_decode (
  input  wire logic [1:0]  gate_code,
  input  wire logic [1:0]  zc_code,
  input  wire logic [1:0]  cal_code,
  input  wire logic [1:0]  sync_code,
  input  wire logic        ival_fast,
  input  wire logic [3:0]  idiss_code,
  input  wire logic        linear_sel,
  output logic      [3:0]  gate_pct,
  output logic      [8:0]  zc_us,
  output logic      [10:0] cal_min_ms,
  output logic      [10:0] cal_max_ms,
  output logic      [2:0]  sync_limit,
  output logic      [12:0] ival_us,
  output logic      [8:0]  idiss_us
);
  import drive_option_pkg::*;

  // ----------------------------------------------------------------------
  // Lookup tables
  // ----------------------------------------------------------------------
  always_comb begin
    case (gate_code)
      2'h0:    gate_pct = 4'h0;
      2'h1:    gate_pct = 4'h2;
      2'h2:    gate_pct = 4'h4;
      default: gate_pct = 4'h8;
    endcase
    case (zc_code)
      2'h0:    zc_us = 9'd100;
      2'h1:    zc_us = 9'd200;
      2'h2:    zc_us = 9'd300;
      default: zc_us = 9'd390;
    endcase
    case (cal_code)
      2'h0:    begin cal_min_ms = 11'd150;  cal_max_ms = 11'd350;  end
      2'h1:    begin cal_min_ms = 11'd250;  cal_max_ms = 11'd450;  end
      2'h2:    begin cal_min_ms = 11'd500;  cal_max_ms = 11'd700;  end
      default: begin cal_min_ms = 11'd1000; cal_max_ms = 11'd1200; end
    endcase
    sync_limit = 3'(SYNC_BASE) + {1'b0, sync_code};
    ival_us = ival_fast ? 13'(IVAL_FAST_US) : 13'(IVAL_SLOW_US);
    // Rotating mass only honours the two low code bits
    if (!linear_sel) begin
      case (idiss_code[1:0])
        2'h0:    idiss_us = 9'd45;
        2'h1:    idiss_us = 9'd75;
        2'h2:    idiss_us = 9'd150;
        default: idiss_us = 9'd225;
      endcase
    end else begin
      case (idiss_code)
        4'h0:    idiss_us = 9'd15;
        4'h1:    idiss_us = 9'd25;
        4'h2:    idiss_us = 9'd50;
        4'h3:    idiss_us = 9'd75;
        4'h4:    idiss_us = 9'd90;
        4'h5:    idiss_us = 9'd105;
        4'h6:    idiss_us = 9'd120;
        4'h7:    idiss_us = 9'd135;
        4'h8:    idiss_us = 9'd150;
        4'h9:    idiss_us = 9'd165;
        4'hA:    idiss_us = 9'd180;
        4'hB:    idiss_us = 9'd195;
        4'hC:    idiss_us = 9'd210;
        4'hD:    idiss_us = 9'd235;
        4'hE:    idiss_us = 9'd260;
        default: idiss_us = 9'd285;
      endcase
    end
  end

endmodule // option_time_decode

// ==== haptic_drive_option_regs.sv ====
// Purpose : Option register bank for a haptic actuator driver
// Assumes : Register port comes from the serial slave, synchronous to clk
// Notes   : Every output is a flip-flop; decoded times are in clk cycles
//
// Overview of operation
// - Gate code 0..3: off, 2, 4, 8 percent
// - Rotating mass: 0 closed, 1 open loop
// - Compensation-off bit 1 disables supply compensation
// - Realtime samples signed at 0, unsigned at 1
// - Linear amplitude update once or twice per cycle
// - Mode 3 input: PWM at 0, analog at 1
// - Fixed-frequency linear drive ignores measured resonance
// - PWM mode commutation is PWM frequency over 128
// - Other modes take frequency from period field
// - Zero-cross window 100, 200, 300, 390 us
// - Calibration time window chosen by two-bit code
// - Fallback after 3 to 6 sync attempts
// - Fallback enable lets linear drive go open loop
// - Playback step 5 ms at 0, 1 ms at 1
// - Fifth register bits 3-2 are blank code top
// - Fifth register bits 1-0 are dissipation code top
// - Fixed period equals field times 98.46 us
// - Dissipation code meaning depends on actuator type

`timescale 1ns/10ps

module haptic_drive_option_regs #(
  parameter int CYC_PER_US = drive_option_pkg::NS_PER_US /
                             drive_option_pkg::CLK_PERIOD_NS
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic                        actuator_type_select,
  input  wire logic [2:0]                  op_mode,
  input  wire logic                        pwm_edge,
  input  wire logic                        bemf_seen,
  input  wire logic                        bemf_miss,
  input  wire logic                        drive_restart,
  input  wire logic                        playback_active,
  output logic      [3:0]                  input_gate_pct,
  output logic                             rotating_open_loop,
  output logic                             vdd_compensation_on,
  output logic                             sample_unsigned,
  output logic                             update_twice,
  output logic                             input_is_analog,
  output logic                             linear_fixed_freq_drive,
  output drive_option_pkg::freq_src_e      freq_source,
  output logic      [31:0]                 fixed_period_cyc,
  output logic                             pwm_commute,
  output logic      [31:0]                 zero_cross_cyc,
  output logic      [31:0]                 cal_min_cyc,
  output logic      [31:0]                 cal_max_cyc,
  output logic      [31:0]                 idiss_cyc,
  output logic      [3:0]                  sense_blank_code,
  output logic                             fallback_active,
  output logic                             playback_step
);
  import drive_option_pkg::*;

  initial begin
    if (CYC_PER_US < 1 || CYC_PER_US > 100)
      $error("CYC_PER_US must lie in 1..100");
  end

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LOOP_TRACK    = 2'b01,
    LOOP_FALLBACK = 2'b10
  } loop_state_e;

  typedef struct packed {
    logic [7:0]  opt;        // drive option register
    logic [3:0]  tcal;       // timing/calibration upper nibble
    logic [7:0]  fbk;        // fallback/interval register
    logic [6:0]  per;        // fixed drive period field
    logic [7:0]  rdata;
    logic        rvalid;
    loop_state_e loop;
    logic [2:0]  miss_cnt;
    logic [6:0]  pwm_cnt;
    logic        commute;
    logic [31:0] step_cnt;
    logic        step;
    logic [3:0]  gate;
    logic        fixed;
    freq_src_e   fsrc;
    logic [31:0] per_cyc;
    logic [31:0] zc_cyc;
    logic [31:0] cmin_cyc;
    logic [31:0] cmax_cyc;
    logic [31:0] idiss_cyc;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [3:0]  gate_pct;
  logic [8:0]  zc_us;
  logic [10:0] cal_min_ms;
  logic [10:0] cal_max_ms;
  logic [2:0]  sync_limit;
  logic [12:0] ival_us;
  logic [8:0]  idiss_us;

  // Time in us to a cycle count at the configured rate
  function automatic logic [31:0] us_to_cyc(input logic [31:0] us);
    return 32'(64'(us) * 64'(CYC_PER_US));
  endfunction

  // ----------------------------------------------------------------------
  // Code decoding
  // ----------------------------------------------------------------------
  option_time_decode u_decode (
    .gate_code  (s_q.opt[GATE_HI:GATE_LO]),
    .zc_code    (s_q.tcal[ZC_HI:ZC_LO]),
    .cal_code   (s_q.tcal[CAL_HI:CAL_LO]),
    .sync_code  (s_q.fbk[SYNC_HI:SYNC_LO]),
    .ival_fast  (s_q.fbk[BIT_IVAL]),
    .idiss_code ({s_q.fbk[IDISS_HI:IDISS_LO], 2'b00}),
    .linear_sel (actuator_type_select),
    .gate_pct   (gate_pct),
    .zc_us      (zc_us),
    .cal_min_ms (cal_min_ms),
    .cal_max_ms (cal_max_ms),
    .sync_limit (sync_limit),
    .ival_us    (ival_us),
    .idiss_us   (idiss_us)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic        pwm_mode;
    logic        analog_mode;
    logic [31:0] ival_cyc;
    s_d         = s_q;
    pwm_mode    = (op_mode == MODE_PWM_ANALOG);
    analog_mode = pwm_mode && s_q.opt[BIT_ANALOG];
    ival_cyc    = us_to_cyc(32'(ival_us));

    // Register writes; reserved nibble and period top bit are dropped
    if (reg_wr) begin
      case (reg_addr)
        ADDR_DRIVE_OPTION: s_d.opt  = reg_wdata;
        ADDR_TIMING_CAL:   s_d.tcal = reg_wdata[7:4];
        ADDR_FALLBACK:     s_d.fbk  = reg_wdata;
        ADDR_OL_PERIOD:    s_d.per  = reg_wdata[6:0];
        default:           ;
      endcase
    end

    // Register reads, answered one cycle later; unmapped reads zero
    s_d.rvalid = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DRIVE_OPTION: s_d.rdata = s_q.opt;
        ADDR_TIMING_CAL:   s_d.rdata = {s_q.tcal, 4'h0};
        ADDR_FALLBACK:     s_d.rdata = s_q.fbk;
        ADDR_OL_PERIOD:    s_d.rdata = {1'b0, s_q.per};
        default:           s_d.rdata = 8'h00;
      endcase
    end

    // Fixed frequency is withheld from analog input as a safety net,
    // since that pairing has no defined frequency source
    s_d.fixed = s_q.opt[BIT_LIN_OL] && !analog_mode;
    if (!s_d.fixed)
      s_d.fsrc = FREQ_AUTO;
    else if (pwm_mode)
      s_d.fsrc = FREQ_PWM;
    else
      s_d.fsrc = FREQ_PERIOD;

    // Divide PWM edges by 128 into commutation pulses
    s_d.commute = 1'b0;
    if (s_q.fsrc == FREQ_PWM) begin
      if (pwm_edge) begin
        s_d.pwm_cnt = s_q.pwm_cnt + 7'h01;
        s_d.commute = (s_q.pwm_cnt == 7'(PWM_DIVIDE - 1));
      end
    end else begin
      s_d.pwm_cnt = 7'h00;
    end

    // Decoded timing, registered so outputs come from flops
    s_d.gate      = gate_pct;
    s_d.per_cyc   = 32'((64'(s_q.per) * 64'(OL_STEP_NS) * 64'(CYC_PER_US))
                        / 64'(NS_PER_US));
    s_d.zc_cyc    = us_to_cyc(32'(zc_us));
    s_d.cmin_cyc  = us_to_cyc(32'(cal_min_ms) * 32'(US_PER_MS));
    s_d.cmax_cyc  = us_to_cyc(32'(cal_max_ms) * 32'(US_PER_MS));
    s_d.idiss_cyc = us_to_cyc(32'(idiss_us));

    // Fallback to open loop after missed back-EMF sync attempts
    case (s_q.loop)
      LOOP_TRACK: begin
        if (bemf_seen) begin
          s_d.miss_cnt = 3'h0;
        end else if (bemf_miss && actuator_type_select) begin
          s_d.miss_cnt = s_q.miss_cnt + 3'h1;
          if (s_q.fbk[BIT_FBEN]
              && (s_q.miss_cnt + 3'h1) >= sync_limit)
            s_d.loop = LOOP_FALLBACK;
        end
      end
      LOOP_FALLBACK: begin
        // Dropping the enable also releases the fallback
        if (drive_restart || !s_q.fbk[BIT_FBEN] || !actuator_type_select) begin
          s_d.loop     = LOOP_TRACK;
          s_d.miss_cnt = 3'h0;
        end
      end
      default: begin
        s_d.loop     = LOOP_TRACK;
        s_d.miss_cnt = 3'h0;
      end
    endcase
    if (drive_restart && s_q.loop == LOOP_TRACK)
      s_d.miss_cnt = 3'h0;

    // Memory playback step ticker
    s_d.step = 1'b0;
    if (!playback_active) begin
      s_d.step_cnt = 32'h0;
    end else if (s_q.step_cnt >= ival_cyc - 32'h1) begin
      s_d.step_cnt = 32'h0;
      s_d.step     = 1'b1;
    end else begin
      s_d.step_cnt = s_q.step_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{opt: RST_DRIVE_OPTION, tcal: RST_TIMING_CAL,
               fbk: RST_FALLBACK, per: RST_OL_PERIOD,
               loop: LOOP_TRACK, fsrc: FREQ_AUTO, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------------
  assign reg_rdata               = s_q.rdata;
  assign reg_rvalid              = s_q.rvalid;
  assign input_gate_pct          = s_q.gate;
  assign rotating_open_loop      = s_q.opt[BIT_ROT_OL];
  assign vdd_compensation_on     = ~s_q.opt[BIT_COMP_OFF];
  assign sample_unsigned         = s_q.opt[BIT_UNSIGNED];
  assign update_twice            = s_q.opt[BIT_TWICE];
  assign input_is_analog         = s_q.opt[BIT_ANALOG];
  assign linear_fixed_freq_drive = s_q.fixed;
  assign freq_source             = s_q.fsrc;
  assign fixed_period_cyc        = s_q.per_cyc;
  assign pwm_commute             = s_q.commute;
  assign zero_cross_cyc          = s_q.zc_cyc;
  assign cal_min_cyc             = s_q.cmin_cyc;
  assign cal_max_cyc             = s_q.cmax_cyc;
  assign idiss_cyc               = s_q.idiss_cyc;
  // Blank code top bits from fifth register, low bits tied to zero
  assign sense_blank_code        = {s_q.fbk[BLANK_HI:BLANK_LO], 2'b00};
  assign fallback_active         = s_q.loop[1];
  assign playback_step           = s_q.step;

endmodule // haptic_drive_option_regs

// ==== haptic_drive_option_regs_sva.sv ====
// Purpose: Port checks for the drive option register bank
// Assumes: One clock, asynchronous active-high reset
// Notes  : Bound into every instance of the bank

`timescale 1ns/10ps

module drive_option_sva
  import drive_option_pkg::*;
#(
  parameter int CYC_PER_US = 100
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       actuator_type_select,
  input wire logic       pwm_edge,
  input wire logic       bemf_miss,
  input wire logic       drive_restart,
  input wire logic       playback_active,
  input wire logic [3:0] input_gate_pct,
  input wire logic       vdd_compensation_on,
  input wire logic       sample_unsigned,
  input wire logic       linear_fixed_freq_drive,
  input wire logic       input_is_analog,
  input drive_option_pkg::freq_src_e freq_source,
  input wire logic       pwm_commute,
  input wire logic       fallback_active,
  input wire logic       playback_step
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ------------------------------
  // Register port
  // ------------------------------
  sequence opt_wr;
    reg_wr && reg_addr == ADDR_DRIVE_OPTION;
  endsequence

  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  unmapped_zero_a: assert property (reg_rd &&
    !(reg_addr inside {[8'h1D:8'h20]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_low_a: assert property (reg_rd &&
    reg_addr == ADDR_TIMING_CAL |=> reg_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");
  period_top_a: assert property (reg_rd &&
    reg_addr == ADDR_OL_PERIOD |=> !reg_rdata[7])
    else $error("period top bit not zero");

  // ------------------------------
  // Decoded options
  // ------------------------------
  gate_table_a: assert property (
    input_gate_pct inside {4'h0, 4'h2, 4'h4, 4'h8})
    else $error("gate level outside table");
  comp_follow_a: assert property (opt_wr ##1 !opt_wr |=>
    vdd_compensation_on == !$past(reg_wdata[BIT_COMP_OFF], 2))
    else $error("compensation bit not followed");
  sign_follow_a: assert property (opt_wr ##1 !opt_wr |=>
    sample_unsigned == $past(reg_wdata[BIT_UNSIGNED], 2))
    else $error("sample format not followed");
  analog_fixed_a: assert property (freq_source == FREQ_PWM |->
    linear_fixed_freq_drive && !$past(input_is_analog))
    else $error("pwm source with analog input");
  commute_cause_a: assert property (pwm_commute |->
    $past(pwm_edge) && $past(freq_source) == FREQ_PWM ##1 !pwm_commute)
    else $error("commutation pulse without cause");

  // ------------------------------
  // Fallback and playback
  // ------------------------------
  fallback_cause_a: assert property ($rose(fallback_active) |->
    $past(bemf_miss) && $past(actuator_type_select))
    else $error("fallback without a missed attempt");
  restart_exit_a: assert property (
    drive_restart |=> !fallback_active)
    else $error("fallback kept after restart");
  step_active_a: assert property (
    playback_step |-> $past(playback_active))
    else $error("playback step while idle");

  cover property (pwm_commute);
  cover property ($rose(fallback_active));
  cover property (playback_step);
endmodule // drive_option_sva

bind haptic_drive_option_regs drive_option_sva #(
  .CYC_PER_US(CYC_PER_US)
) chk_i (
  .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .reg_rvalid, .actuator_type_select, .pwm_edge, .bemf_miss,
  .drive_restart, .playback_active, .input_gate_pct,
  .vdd_compensation_on, .sample_unsigned, .linear_fixed_freq_drive,
  .input_is_analog, .freq_source, .pwm_commute, .fallback_active,
  .playback_step
);

// ==== host_reg_model.sv ====
// Purpose: Host side of the option register port
// Assumes: Strobes change on falling clock edges only
// Notes  : Idle address and data show inverted values, never stale

`timescale 1ns/10ps

module host_reg_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Quiet bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe, then lines scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  // Read with a bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    ok       = 1'b0;
    d        = 8'h00;
    for (n = 0; n < 3 && !ok; n++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // host_reg_model

// ==== haptic_drive_option_regs_tb_top.sv ====
// Purpose: Self-checking bench for the drive option register bank
// Assumes: Time scale shrunk to one cycle per microsecond
// Notes  : Inputs change on falling edges only

`timescale 1ns/10ps

module haptic_drive_option_regs_tb_top;
  import drive_option_pkg::*;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic        actuator_type_select = 1'b0;
  logic [2:0]  op_mode = 3'h0;
  logic        pwm_edge = 1'b0;
  logic        bemf_seen = 1'b0;
  logic        bemf_miss = 1'b0;
  logic        drive_restart = 1'b0;
  logic        playback_active = 1'b0;
  logic [3:0]  input_gate_pct, sense_blank_code;
  logic        rotating_open_loop, vdd_compensation_on, sample_unsigned;
  logic        update_twice, input_is_analog, linear_fixed_freq_drive;
  freq_src_e   freq_source;
  logic [31:0] fixed_period_cyc, zero_cross_cyc, cal_min_cyc;
  logic [31:0] cal_max_cyc, idiss_cyc;
  logic        pwm_commute, fallback_active, playback_step;
  int          fails = 0;
  int          checks_done = 0;

  localparam logic [3:0] PCT [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
  localparam int ZC [4] = '{100, 200, 300, 390};
  localparam int CALMS [4] = '{150, 250, 500, 1000};

  // 100 MHz clock
  always #5 clk = ~clk;

  // One microsecond per cycle keeps millisecond timers short
  haptic_drive_option_regs #(.CYC_PER_US(1)) uut (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .actuator_type_select, .op_mode, .pwm_edge, .bemf_seen,
    .bemf_miss, .drive_restart, .playback_active, .input_gate_pct,
    .rotating_open_loop, .vdd_compensation_on, .sample_unsigned,
    .update_twice, .input_is_analog, .linear_fixed_freq_drive,
    .freq_source, .fixed_period_cyc, .pwm_commute, .zero_cross_cyc,
    .cal_min_cyc, .cal_max_cyc, .idiss_cyc, .sense_blank_code,
    .fallback_active, .playback_step
  );

  host_reg_model host (
    .clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid
  );

  // ------------------------------
  // Shared helpers
  // ------------------------------
  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Write, then let the decoded outputs settle
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    cyc(3);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    host.rd(a, d, ok);
    if (!ok) begin
      fails++;
      test_done();
    end
  endtask

  task automatic pulse_miss(input int n);
    repeat (n) begin
      bemf_miss = 1'b1;
      @(negedge clk);
    end
    bemf_miss = 1'b0;
    cyc(2);
  endtask

  task automatic restart();
    drive_restart = 1'b1;
    cyc(1);
    drive_restart = 1'b0;
    cyc(2);
  endtask

  // Cycles between two playback steps, bounded
  task automatic gap(output int n);
    int w;
    n = 0;
    for (w = 0; w < 6000 && playback_step !== 1'b1; w++)
      @(negedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (playback_step !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      fails++;
      test_done();
    end
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_defaults();
    logic [7:0] d;
    logic [7:0] ex [5];
    ex = '{RST_DRIVE_OPTION, {RST_TIMING_CAL, 4'h0}, RST_FALLBACK,
           {1'b0, RST_OL_PERIOD}, 8'h00};
    cyc(2);
    chk(input_gate_pct, 4'h4);
    chk(zero_cross_cyc, 32'd100);
    chk(cal_max_cyc, 32'd700000);
    for (int i = 0; i < 5; i++) begin
      rdv(ADDR_DRIVE_OPTION + 8'(i), d);
      chk(d, ex[i]);
    end
  endtask

  task automatic t_reserved();
    logic [7:0] d;
    wrs(ADDR_TIMING_CAL, 8'hFF);
    rdv(ADDR_TIMING_CAL, d);
    chk(d, 8'hF0);
    wrs(ADDR_OL_PERIOD, 8'hFF);
    rdv(ADDR_OL_PERIOD, d);
    chk(d, 8'h7F);
    wrs(ADDR_OL_PERIOD, 8'h64);
    chk(fixed_period_cyc, 32'd9846);
    wrs(8'h05, 8'hFF);
    rdv(8'h05, d);
    chk(d, 8'h00);
  endtask

  // Every gate code; option bits 5 to 1 toggled together, bit 0 held low
  task automatic t_options();
    logic b;
    for (int g = 0; g < 4; g++) begin
      b = g[0];
      wrs(ADDR_DRIVE_OPTION, {g[1:0], {5{b}}, 1'b0});
      chk(input_gate_pct, PCT[g]);
      chk(rotating_open_loop, b);
      chk(vdd_compensation_on, !b);
      chk(sample_unsigned, b);
      chk(update_twice, b);
      chk(input_is_analog, b);
    end
  endtask

  task automatic t_times();
    for (int k = 0; k < 4; k++) begin
      wrs(ADDR_TIMING_CAL, {k[1:0], k[1:0], 4'h5});
      chk(zero_cross_cyc, ZC[k]);
      chk(cal_min_cyc, CALMS[k] * 1000);
      chk(cal_max_cyc, (CALMS[k] + 200) * 1000);
    end
  endtask

  // Frequency sources and the divide-by-128 path
  task automatic t_freq();
    int first;
    int cnt;
    first = 0;
    cnt = 0;
    actuator_type_select = 1'b1;
    wrs(ADDR_DRIVE_OPTION, 8'h00);
    chk(freq_source, FREQ_AUTO);
    wrs(ADDR_DRIVE_OPTION, 8'h01);
    chk(linear_fixed_freq_drive, 1'b1);
    chk(freq_source, FREQ_PERIOD);
    op_mode = MODE_PWM_ANALOG;
    cyc(3);
    chk(freq_source, FREQ_PWM);
    for (int i = 0; i < 258; i++) begin
      pwm_edge = (i < 255);
      @(negedge clk);
      if (pwm_commute === 1'b1) begin
        cnt++;
        if (first == 0)
          first = i + 1;
      end
    end
    chk(first, 128);
    chk(cnt, 1);
    wrs(ADDR_DRIVE_OPTION, 8'h03);
    chk(linear_fixed_freq_drive, 1'b0);
    op_mode = 3'h0;
  endtask

  // Attempt counts, back-EMF clearing and disabled fallback
  task automatic t_fallback();
    for (int c = 0; c < 4; c++) begin
      wrs(ADDR_FALLBACK, {c[1:0], 6'h20});
      restart();
      pulse_miss(c + 2);
      chk(fallback_active, 1'b0);
      pulse_miss(1);
      chk(fallback_active, 1'b1);
    end
    restart();
    chk(fallback_active, 1'b0);
    wrs(ADDR_FALLBACK, 8'h20);
    pulse_miss(2);
    bemf_seen = 1'b1;
    cyc(1);
    bemf_seen = 1'b0;
    pulse_miss(2);
    chk(fallback_active, 1'b0);
    pulse_miss(1);
    chk(fallback_active, 1'b1);
    wrs(ADDR_FALLBACK, 8'hC0);
    restart();
    pulse_miss(8);
    chk(fallback_active, 1'b0);
  endtask

  task automatic t_codes();
    wrs(ADDR_FALLBACK, 8'h0D);
    chk(sense_blank_code, 4'hC);
    chk(idiss_cyc, 32'd90);
    actuator_type_select = 1'b0;
    cyc(3);
    chk(idiss_cyc, 32'd45);
  endtask

  task automatic t_playback();
    int n;
    wrs(ADDR_FALLBACK, 8'h10);
    playback_active = 1'b1;
    gap(n);
    chk(n, 1000);
    playback_active = 1'b0;
    wrs(ADDR_FALLBACK, 8'h00);
    playback_active = 1'b1;
    gap(n);
    chk(n, 5000);
    playback_active = 1'b0;
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    cyc(10);
    rst = 1'b0;
    t_defaults();
    t_reserved();
    t_options();
    t_times();
    t_freq();
    t_fallback();
    t_codes();
    t_playback();
    test_done();
  end
endmodule // haptic_drive_option_regs_tb_top
